// >>> ccdt_pkg.sv
// Shared constants for the linear CCD line readout timing generator
`default_nettype none

package ccdt_pkg;

  // Counter width for line and interval counts
  localparam int LW = 24;

  // Reference clock period in picoseconds (250 MHz)
  localparam int CLK_PS = 4000;

  // Sensor geometry
  localparam int NPIX       = 2092;
  localparam int NEFF       = 2048;
  localparam int LEAD_DUMMY = 22;

  // Interval times in ns, figures as used for the waveform
  localparam int V1_NS      = 1000;   // First transfer gate interval, least
  localparam int V2_NS      = 8000;   // First transfer gate second interval, nominal
  localparam int AR1_MIN_NS = 2000;   // First all-reset interval, least
  localparam int AR2_NS     = 1000;   // All-reset intervals two to five, nominal
  localparam int AR3_NS     = 2000;
  localparam int AR4_NS     = 5000;
  localparam int AR5_NS     = 1000;
  localparam int PWT_NS     = 2000;   // Second transfer gate pulse, nominal
  localparam int PWH_NS     = 200;    // Horizontal phase pulse, nominal
  localparam int RG_NS      = 60;     // Output reset gate pulse, nominal
  localparam int INTEG_MIN_NS = 6000; // Integration time, least
  localparam int OVG_NS     = 200;    // Phase A lead ahead of the transfer pulse

  // Cycle counts; least times round up
  localparam logic [LW-1:0] V1_CYC  = LW'((V1_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] V2_CYC  = LW'((V2_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] AR1_MIN_CYC = LW'((AR1_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] AR2_CYC = LW'((AR2_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] AR3_CYC = LW'((AR3_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] AR4_CYC = LW'((AR4_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] AR5_CYC = LW'((AR5_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] PWT_CYC = LW'((PWT_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] PWH_CYC = LW'((PWH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] RG_CYC  = LW'((RG_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] OVG_CYC = LW'((OVG_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [LW-1:0] INTEG_MIN_CYC = LW'((INTEG_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // Pixel period and the points inside it
  localparam logic [LW-1:0] PIX_CYC      = LW'(2) * PWH_CYC;
  localparam logic [LW-1:0] RG_START_CYC = PWH_CYC + (PWH_CYC - RG_CYC) / LW'(2);
  localparam logic [LW-1:0] SAMPLE_CYC   = PWH_CYC / LW'(2);

  // Line states
  typedef enum logic [0:0] {LN_READ, LN_HOLD} ccdt_line_t;

endpackage : ccdt_pkg

`default_nettype wire

// >>> ccdt_sync.sv
// Two-flop synchroniser for a level or a gray-coded word
`default_nettype none

module ccdt_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,  // Destination clock
  input  wire logic [W-1:0] i_d,    // Asynchronous input
  output var  logic [W-1:0] o_q     // Synchronised output
);

  logic [W-1:0] meta_r;

  // Only the second flop reads the first; no reset so reset itself can pass through
  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    o_q    <= meta_r;
  end

endmodule : ccdt_sync

`default_nettype wire

// >>> ccdt_afifo.sv
// Dual-clock FIFO with gray-coded pointers and registered full and empty
`default_nettype none

module ccdt_afifo #(
  parameter int DW    = 16,
  parameter int DEPTH = 8
) (
  input  wire logic          i_wr_clk,    // Write clock
  input  wire logic          i_wr_rst_b,  // Write reset, sync, active low
  input  wire logic          i_wr_valid,  // Write request
  input  wire logic [DW-1:0] i_wr_data,   // Write data
  output var  logic          o_wr_ready,  // Room for a word
  input  wire logic          i_rd_clk,    // Read clock
  input  wire logic          i_rd_rst_b,  // Read reset, sync, active low
  output var  logic          o_rd_valid,  // Word available
  output var  logic [DW-1:0] o_rd_data,   // Head word
  input  wire logic          i_rd_ready   // Reader takes the head word
);

  localparam int AW = $clog2(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [AW:0]   wbin_r, wgray_r, wbin_nxt, wgray_nxt, rq_gray;
  logic [AW:0]   rbin_r, rgray_r, rbin_nxt, rgray_nxt, wq_gray;
  logic          empty_r;
  logic          push, pop;

  assign push = i_wr_valid && o_wr_ready;
  assign pop  = i_rd_ready && !empty_r;
  assign wbin_nxt  = wbin_r + (AW+1)'(push);
  assign wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
  assign rbin_nxt  = rbin_r + (AW+1)'(pop);
  assign rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
  assign o_rd_valid = !empty_r;
  assign o_rd_data  = mem[rbin_r[AW-1:0]];

  // Storage, written only in the write domain
  always_ff @(posedge i_wr_clk) begin
    if (push) begin
      mem[wbin_r[AW-1:0]] <= i_wr_data;
    end
  end

  // Write pointer and full; ready drops the cycle the last slot fills
  always_ff @(posedge i_wr_clk) begin
    if (!i_wr_rst_b) begin
      wbin_r     <= '0;
      wgray_r    <= '0;
      o_wr_ready <= 1'b0;
    end else begin
      wbin_r     <= wbin_nxt;
      wgray_r    <= wgray_nxt;
      o_wr_ready <= (wgray_nxt != {~rq_gray[AW:AW-1], rq_gray[AW-2:0]});
    end
  end

  // Read pointer and empty
  always_ff @(posedge i_rd_clk) begin
    if (!i_rd_rst_b) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      empty_r <= 1'b1;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rgray_nxt;
      empty_r <= (rgray_nxt == wq_gray);
    end
  end

  // Pointer crossings, gray code so only one bit moves at a time
  ccdt_sync #(.W(AW+1)) u_sync_r2w (
    .i_clk (i_wr_clk),
    .i_d   (rgray_r),
    .o_q   (rq_gray)
  );

  ccdt_sync #(.W(AW+1)) u_sync_w2r (
    .i_clk (i_rd_clk),
    .i_d   (wgray_r),
    .o_q   (wq_gray)
  );

endmodule : ccdt_afifo

`default_nettype wire

// >>> ccdt_top.sv
// Line readout timing generator that drives a linear CCD and gathers its samples
//
// Contract
// - First transfer gate intervals: 1 us, 4 us; the code uses 1 us and 8 us
// - First all-reset interval at least 2 us
// - All-reset intervals two to five meet minimums
// - Second transfer gate pulse at least 1 us
// - Horizontal phases at least 100 ns wide
// - Horizontal phase duty between 40 and 60
// - Summing gate follows phase B timing
// - Output reset gate pulse at least 30 ns
// - Transfer pulse overlaps phase A 1 us
// - Integration time at least 6 us
// - Integration set by the four interval sum
// - Line period change retunes first all-reset interval
// - Dummy readouts flush until next transfer
// - 2092 positions per line, 2048 valid
// - Horizontal register uses two-phase clocks
// - Pixel rate at most 5 MHz
`default_nettype none

module ccdt_top
  import ccdt_pkg::*;
#(
  parameter int NPIX_P  = NPIX,        // Positions shifted per line
  parameter int NEFF_P  = NEFF,        // Effective positions
  parameter int LEAD_P  = LEAD_DUMMY,  // Positions before the first effective one
  parameter int DW      = 16,          // Sample width
  parameter int DEPTH   = 8            // Sample FIFO depth
) (
  input  wire logic          i_ref_clk,              // 250 MHz system clock
  input  wire logic          i_rst_b,                // Sync reset, active low
  input  wire logic [LW-1:0] i_integ_len,            // Wanted integration, cycles
  output var  logic          o_first_transfer_gate,  // Sensor pin drive
  output var  logic          o_second_transfer_gate, // Sensor pin drive
  output var  logic          o_all_reset_gate,       // Sensor pin drive
  output var  logic          o_horiz_phase_a,        // Sensor pin drive
  output var  logic          o_horiz_phase_b,        // Sensor pin drive
  output var  logic          o_summing_gate,         // Sensor pin drive
  output var  logic          o_output_reset_gate,    // Sensor pin drive
  output var  logic          o_adc_conv,             // Convert strobe to the ADC
  output var  logic          o_line_start,           // Pulse at each line start
  output var  logic [LW-1:0] o_integ_act,            // Integration of the current line
  input  wire logic          i_adc_clk,              // ADC link clock
  input  wire logic          i_adc_valid,            // ADC sample valid
  input  wire logic [DW-1:0] i_adc_data,             // ADC sample
  output var  logic          o_adc_ready,            // FIFO can take a sample
  output var  logic          o_pix_valid,            // Effective pixel out
  output var  logic [DW-1:0] o_pix_data,             // Pixel value
  output var  logic          o_pix_first,            // First effective pixel of a line
  input  wire logic          i_pix_ready             // Consumer takes the pixel
);

  // Fixed tail of a line after the end of the first all-reset interval
  localparam logic [LW-1:0] TAIL_CYC = AR2_CYC + AR3_CYC + AR4_CYC + AR5_CYC
                                     + V2_CYC + PWT_CYC;
  // Shortest line: all positions clocked, the transfer window, and the reset chain
  localparam logic [LW-1:0] READ_MIN_CYC = LW'(NPIX_P) * PIX_CYC + PWT_CYC + OVG_CYC;
  localparam logic [LW-1:0] RST_MIN_CYC  = AR1_MIN_CYC + TAIL_CYC;
  localparam logic [LW-1:0] LMIN_CYC = (READ_MIN_CYC > RST_MIN_CYC) ? READ_MIN_CYC
                                                                   : RST_MIN_CYC;
  localparam logic [LW-1:0] NPIX_W = LW'(NPIX_P);
  localparam logic [LW-1:0] LEAD_W = LW'(LEAD_P);
  localparam logic [LW-1:0] LAST_W = LW'(LEAD_P + NEFF_P);

  ccdt_line_t    line_st_r;
  logic [LW-1:0] line_len_r;
  logic [LW-1:0] lcnt_r;
  logic [LW-1:0] pcnt_r;
  logic [LW-1:0] pix_idx_r;
  logic [LW-1:0] pos_r;

  logic [LW-1:0] integ_req;
  logic [LW-1:0] len_req;
  logic [LW-1:0] len_nxt;
  logic [LW-1:0] t2_rise;
  logic [LW-1:0] hold_start;
  logic [LW-1:0] tg1b_start;
  logic [LW-1:0] e1, e2, e3, e4;
  logic [LW-1:0] tg1a_start;
  logic          line_end;
  logic          pix_end;
  logic          pix_fits;

  logic          arg_nxt;
  logic          tg1_nxt;
  logic          tg2_nxt;
  logic          pha_nxt;
  logic          phb_nxt;
  logic          rg_nxt;
  logic          conv_nxt;

  logic          wr_rst_b;
  logic          fifo_valid;
  logic [DW-1:0] fifo_data;
  logic          fifo_take;
  logic          keep_pos;

  // Line schedule, counted back from the end of the line
  assign t2_rise    = line_len_r - PWT_CYC;
  assign hold_start = t2_rise - OVG_CYC;
  assign tg1b_start = t2_rise - V2_CYC;
  assign e4         = tg1b_start - AR5_CYC;
  assign e3         = e4 - AR4_CYC;
  assign e2         = e3 - AR3_CYC;
  assign e1         = e2 - AR2_CYC;
  assign tg1a_start = e1 - V1_CYC;
  assign line_end   = (lcnt_r == line_len_r - LW'(1));
  assign pix_end    = (pcnt_r == PIX_CYC - LW'(1));
  // A further pixel is started only if it ends before the transfer window
  assign pix_fits   = (lcnt_r + LW'(1) + PIX_CYC) <= hold_start;

  // Line length follows the wanted integration; short requests are raised
  always_comb begin
    integ_req = (i_integ_len < INTEG_MIN_CYC) ? INTEG_MIN_CYC : i_integ_len;
    len_req   = integ_req + V1_CYC + AR3_CYC + AR4_CYC + AR5_CYC + PWT_CYC;
    len_nxt   = (len_req < LMIN_CYC) ? LMIN_CYC : len_req;
  end

  // Line counter and per-line settings, taken only at the line boundary
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      lcnt_r      <= '0;
      line_len_r  <= LMIN_CYC;
      o_integ_act <= LMIN_CYC - PWT_CYC - AR5_CYC - AR4_CYC - AR3_CYC - V1_CYC;
    end else if (line_end) begin
      lcnt_r      <= '0;
      line_len_r  <= len_nxt;
      // First all-reset interval spans line start to e1, so it stretches with the line
      o_integ_act <= len_nxt - PWT_CYC - AR5_CYC - AR4_CYC - AR3_CYC - V1_CYC;
    end else begin
      lcnt_r <= lcnt_r + LW'(1);
    end
  end

  // Line start marker for the consumer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_line_start <= 1'b0;
    end else begin
      o_line_start <= line_end;
    end
  end

  // Readout state: clock pixels, keep clocking dummies, then hold for the transfer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      line_st_r <= LN_HOLD;
      pcnt_r    <= '0;
      pix_idx_r <= '0;
    end else begin
      case (line_st_r)
        LN_READ: begin
          if (line_end) begin
            pcnt_r    <= '0;
            pix_idx_r <= '0;
          end else if (pix_end) begin
            pcnt_r    <= '0;
            pix_idx_r <= pix_idx_r + LW'(1);
            if (!pix_fits) begin
              line_st_r <= LN_HOLD;
            end
          end else begin
            pcnt_r <= pcnt_r + LW'(1);
          end
        end
        LN_HOLD: begin
          pcnt_r <= '0;
          if (line_end) begin
            line_st_r <= LN_READ;
            pix_idx_r <= '0;
          end
        end
        default: begin
          line_st_r <= LN_HOLD;
          pcnt_r    <= '0;
          pix_idx_r <= '0;
        end
      endcase
    end
  end

  // Horizontal clocks: two equal halves per pixel give 50 percent duty
  always_comb begin
    if (line_st_r == LN_READ) begin
      pha_nxt = (pcnt_r < PWH_CYC);
      phb_nxt = (pcnt_r >= PWH_CYC);
    end else begin
      // Phase A stays high across the transfer pulse and its guards
      pha_nxt = 1'b1;
      phb_nxt = 1'b0;
    end
  end

  // Output reset gate sits mid phase B, clear of the summing gate fall
  always_comb begin
    rg_nxt   = (line_st_r == LN_READ) && (pcnt_r >= RG_START_CYC)
            && (pcnt_r < RG_START_CYC + RG_CYC);
    conv_nxt = (line_st_r == LN_READ) && (pcnt_r == SAMPLE_CYC)
            && (pix_idx_r < NPIX_W);
  end

  // Gate pulses from the line schedule
  always_comb begin
    tg2_nxt = (lcnt_r >= t2_rise);
    tg1_nxt = ((lcnt_r >= tg1a_start) && (lcnt_r < e1))
           || ((lcnt_r >= tg1b_start) && (lcnt_r < t2_rise));
    arg_nxt = (lcnt_r < e1)
           || ((lcnt_r >= e2) && (lcnt_r < e3))
           || ((lcnt_r >= e4) && (lcnt_r < tg1b_start));
  end

  // Pin registers; every pin moves one cycle after its schedule term
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_first_transfer_gate  <= 1'b0;
      o_second_transfer_gate <= 1'b0;
      o_all_reset_gate       <= 1'b0;
      o_horiz_phase_a        <= 1'b0;
      o_horiz_phase_b        <= 1'b0;
      o_summing_gate         <= 1'b0;
      o_output_reset_gate    <= 1'b0;
      o_adc_conv             <= 1'b0;
    end else begin
      o_first_transfer_gate  <= tg1_nxt;
      o_second_transfer_gate <= tg2_nxt;
      o_all_reset_gate       <= arg_nxt;
      o_horiz_phase_a        <= pha_nxt;
      o_horiz_phase_b        <= phb_nxt;
      o_summing_gate         <= phb_nxt;
      o_output_reset_gate    <= rg_nxt;
      o_adc_conv             <= conv_nxt;
    end
  end

  // Reset into the ADC domain
  ccdt_sync #(.W(1)) u_sync_rst (
    .i_clk (i_adc_clk),
    .i_d   (i_rst_b),
    .o_q   (wr_rst_b)
  );

  // Samples cross from the ADC clock through the FIFO; its ready holds the ADC off
  ccdt_afifo #(.DW(DW), .DEPTH(DEPTH)) u_fifo (
    .i_wr_clk   (i_adc_clk),
    .i_wr_rst_b (wr_rst_b),
    .i_wr_valid (i_adc_valid),
    .i_wr_data  (i_adc_data),
    .o_wr_ready (o_adc_ready),
    .i_rd_clk   (i_ref_clk),
    .i_rd_rst_b (i_rst_b),
    .o_rd_valid (fifo_valid),
    .o_rd_data  (fifo_data),
    .i_rd_ready (fifo_take)
  );

  // Pop only when the output stage is free, so a stalled consumer backs up the FIFO
  assign fifo_take = fifo_valid && (!o_pix_valid || i_pix_ready);
  assign keep_pos  = (pos_r >= LEAD_W) && (pos_r < LAST_W);

  // Position within the line; relies on one sample per conversion, none dropped
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pos_r <= '0;
    end else if (fifo_take) begin
      pos_r <= (pos_r == NPIX_W - LW'(1)) ? '0 : pos_r + LW'(1);
    end
  end

  // Output stage keeps effective positions only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_pix_valid <= 1'b0;
      o_pix_data  <= '0;
      o_pix_first <= 1'b0;
    end else if (fifo_take) begin
      o_pix_valid <= keep_pos;
      o_pix_data  <= fifo_data;
      o_pix_first <= (pos_r == LEAD_W);
    end else if (i_pix_ready) begin
      o_pix_valid <= 1'b0;
      o_pix_first <= 1'b0;
    end
  end

endmodule : ccdt_top

`default_nettype wire

// >>> ccdt_top_properties.sv
// Concurrent checks on the sensor pin timing and the pixel stream
`default_nettype none

module ccdt_top_checker
  import ccdt_pkg::*;
#(
  parameter int DW = 16  // Sample width
) (
  input wire logic          i_ref_clk,               // System clock
  input wire logic          i_rst_b,                 // Sync reset, active low
  input wire logic          o_first_transfer_gate,   // Pin
  input wire logic          o_second_transfer_gate,  // Pin
  input wire logic          o_all_reset_gate,        // Pin
  input wire logic          o_horiz_phase_a,         // Pin
  input wire logic          o_horiz_phase_b,         // Pin
  input wire logic          o_summing_gate,          // Pin
  input wire logic          o_output_reset_gate,     // Pin
  input wire logic          o_adc_conv,              // Convert strobe
  input wire logic          o_pix_valid,             // Pixel offered
  input wire logic [DW-1:0] o_pix_data,              // Pixel value
  input wire logic          o_pix_first,             // First effective pixel
  input wire logic          i_pix_ready              // Consumer takes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] b_run_r;
  logic [15:0] tg1_run_r;
  logic [15:0] tg2_run_r;
  logic [15:0] arg_run_r;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // High run lengths; read at the falling edge they give the whole pulse width
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      b_run_r   <= 16'h0;
      tg1_run_r <= 16'h0;
      tg2_run_r <= 16'h0;
      arg_run_r <= 16'h0;
    end else begin
      b_run_r   <= o_horiz_phase_b ? b_run_r + 16'h1 : 16'h0;
      tg1_run_r <= o_first_transfer_gate ? tg1_run_r + 16'h1 : 16'h0;
      tg2_run_r <= o_second_transfer_gate ? tg2_run_r + 16'h1 : 16'h0;
      arg_run_r <= o_all_reset_gate ? arg_run_r + 16'h1 : 16'h0;
    end
  end

  a_sg_follows_b: assert property (o_summing_gate == o_horiz_phase_b)
    else $error("summing gate differs from phase b");
  a_phases_apart: assert property (!(o_horiz_phase_a && o_horiz_phase_b))
    else $error("both horizontal phases high");
  a_phase_b_width: assert property ($fell(o_horiz_phase_b) |-> b_run_r == 16'h32)
    else $error("phase b pulse width wrong");
  a_rg_width: assert property ($rose(o_output_reset_gate) |->
    o_output_reset_gate[*8] ##1 o_output_reset_gate[*7] ##1 !o_output_reset_gate)
    else $error("output reset gate pulse width wrong");
  a_rg_mid_b: assert property ($rose(o_output_reset_gate) |-> b_run_r == 16'h11)
    else $error("output reset gate not inside phase b");
  a_tg2_width: assert property ($fell(o_second_transfer_gate) |-> tg2_run_r == 16'h1f4)
    else $error("second transfer pulse width wrong");
  a_tg2_over_a: assert property (o_second_transfer_gate |-> o_horiz_phase_a)
    else $error("transfer pulse outside phase a");
  a_tg1_width: assert property ($fell(o_first_transfer_gate) |->
    (tg1_run_r == 16'hfa || tg1_run_r == 16'h7d0))
    else $error("first transfer interval wrong");
  a_arg_width: assert property ($fell(o_all_reset_gate) |-> arg_run_r >= 16'hfa)
    else $error("all-reset interval too short");
  a_conv_single: assert property (o_adc_conv |-> o_horiz_phase_a ##1 !o_adc_conv)
    else $error("convert strobe misplaced");
  a_pix_held: assert property (o_pix_valid && !i_pix_ready |=>
    o_pix_valid && $stable(o_pix_data))
    else $error("pixel dropped while stalled");

  c_transfer: cover property ($rose(o_second_transfer_gate));
  c_first_pix: cover property (o_pix_valid && o_pix_first && i_pix_ready);
  c_stalled: cover property (o_pix_valid && !i_pix_ready);
  c_rg_pulse: cover property ($fell(o_output_reset_gate));

endmodule : ccdt_top_checker

bind ccdt_top ccdt_top_checker #(.DW(DW)) u_checker (
  .i_ref_clk, .i_rst_b, .o_first_transfer_gate, .o_second_transfer_gate,
  .o_all_reset_gate, .o_horiz_phase_a, .o_horiz_phase_b, .o_summing_gate,
  .o_output_reset_gate, .o_adc_conv, .o_pix_valid, .o_pix_data, .o_pix_first,
  .i_pix_ready
);

`default_nettype wire

// >>> ccdt_sensor_model.sv
// Behavioural sensor with its ADC: exposure, transfer and serial samples
`default_nettype none

module ccdt_sensor_model
  import ccdt_pkg::*;
#(
  parameter int NPIX_P = NPIX,  // Positions per line
  parameter int DW     = 16     // Sample width
) (
  input  wire logic          i_ref_clk,               // Timing clock
  input  wire logic          i_adc_clk,               // Link clock
  input  wire logic          i_all_reset_gate,        // Clears pixel charge
  input  wire logic          i_second_transfer_gate,  // Moves charge out
  input  wire logic          i_adc_conv,              // One position sampled
  input  wire logic          i_stall,                 // Answer slowly
  input  wire logic          i_adc_ready,             // FIFO has room
  output var  logic          o_adc_valid,             // Sample offered
  output var  logic [DW-1:0] o_adc_data,              // Sample, position index
  output var  logic [LW-1:0] o_exposure               // Charge time at last transfer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LW-1:0] charge_r = '0;
  logic          tg2_d_r  = 1'b0;
  int            pos_r    = 0;
  int            pend_q[$];

  initial begin
    o_adc_valid = 1'b0;
    o_adc_data  = '0;
    o_exposure  = '0;
  end

  // Charge builds while all-reset is low and is dumped while it is high
  always @(posedge i_ref_clk) begin
    charge_r <= i_all_reset_gate ? '0 : charge_r + LW'(1);
    tg2_d_r  <= i_second_transfer_gate;
    if (i_second_transfer_gate && !tg2_d_r) begin
      o_exposure <= charge_r;
    end
  end

  // Each strobe shifts one position; value is the index so loss shows
  always @(posedge i_ref_clk) begin
    if (i_adc_conv) begin
      pend_q.push_back(pos_r);
      pos_r <= (pos_r + 1) % NPIX_P;
    end
  end

  // Offer held until taken; an idle data bus shows the inverse of its last value
  always @(posedge i_adc_clk) begin
    if (o_adc_valid && i_adc_ready) begin
      o_adc_valid <= 1'b0;
      o_adc_data  <= ~o_adc_data;
    end else if (!o_adc_valid && !i_stall && pend_q.size() > 0) begin
      o_adc_valid <= 1'b1;
      o_adc_data  <= DW'(pend_q.pop_front());
    end else if (!o_adc_valid) begin
      o_adc_data <= ~o_adc_data;
    end
  end

endmodule : ccdt_sensor_model

`default_nettype wire

// >>> test_ccdt_top.sv
// Self-checking bench for the line readout timing generator
`default_nettype none

module test_ccdt_top
  import ccdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Short line keeps the run small; expectations follow these values
  localparam int NP  = 64;
  localparam int NE  = 40;
  localparam int LD  = 12;
  localparam int L0  = NP * 100 + 550;
  localparam int TMO = 80000;

  logic          i_ref_clk, i_rst_b, i_adc_clk, i_adc_valid, i_pix_ready, stall;
  logic [LW-1:0] i_integ_len, o_integ_act, exposure;
  logic [15:0]   i_adc_data, o_pix_data;
  logic          o_first_transfer_gate, o_second_transfer_gate, o_all_reset_gate;
  logic          o_horiz_phase_a, o_horiz_phase_b, o_summing_gate, o_output_reset_gate;
  logic          o_adc_conv, o_line_start, o_adc_ready, o_pix_valid, o_pix_first;
  logic          b_d = 1'b0;
  logic          rg_d = 1'b0;
  int            num_errors, num_checks, cyc;
  int            len_cnt, len_last, conv_cnt, conv_last, b_cnt, b_last;
  int            rg_cnt, rg_last, pix_cnt, pix_last;

  ccdt_top #(.NPIX_P(NP), .NEFF_P(NE), .LEAD_P(LD)) dut (
    .i_ref_clk, .i_rst_b, .i_integ_len, .o_first_transfer_gate, .o_second_transfer_gate,
    .o_all_reset_gate, .o_horiz_phase_a, .o_horiz_phase_b, .o_summing_gate,
    .o_output_reset_gate, .o_adc_conv, .o_line_start, .o_integ_act, .i_adc_clk,
    .i_adc_valid, .i_adc_data, .o_adc_ready, .o_pix_valid, .o_pix_data, .o_pix_first,
    .i_pix_ready
  );

  ccdt_sensor_model #(.NPIX_P(NP)) u_sensor (
    .i_ref_clk(i_ref_clk), .i_adc_clk(i_adc_clk), .i_all_reset_gate(o_all_reset_gate),
    .i_second_transfer_gate(o_second_transfer_gate), .i_adc_conv(o_adc_conv),
    .i_stall(stall), .i_adc_ready(o_adc_ready), .o_adc_valid(i_adc_valid),
    .o_adc_data(i_adc_data), .o_exposure(exposure)
  );

  // Link clock is unrelated in phase to the system clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_adc_clk = 1'b0;
    #37;
    forever #62.5 i_adc_clk = ~i_adc_clk;
  end

  task automatic check(string what, logic [LW-1:0] exp, logic [LW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A hang ends the run as a mismatch
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc >= TMO) begin
      num_errors++;
      report_and_stop();
    end
  end

  // Per-line tallies, latched at each line start
  always @(posedge i_ref_clk) begin
    b_d  <= o_horiz_phase_b;
    rg_d <= o_output_reset_gate;
    if (o_line_start) begin
      len_last  <= len_cnt;
      conv_last <= conv_cnt;
      b_last    <= b_cnt;
      rg_last   <= rg_cnt;
      len_cnt   <= 1;
      conv_cnt  <= int'(o_adc_conv);
      b_cnt     <= int'(o_horiz_phase_b && !b_d);
      rg_cnt    <= int'(o_output_reset_gate && !rg_d);
    end else begin
      len_cnt   <= len_cnt + 1;
      conv_cnt  <= conv_cnt + int'(o_adc_conv);
      b_cnt     <= b_cnt + int'(o_horiz_phase_b && !b_d);
      rg_cnt    <= rg_cnt + int'(o_output_reset_gate && !rg_d);
    end
  end

  // Every taken pixel must be the next effective position, in order
  always @(posedge i_ref_clk) begin
    if (o_pix_valid === 1'b1 && i_pix_ready) begin
      pix_cnt <= o_pix_first ? 1 : pix_cnt + 1;
      if (o_pix_first) pix_last <= pix_cnt;
      check("pixel data", LW'(o_pix_first ? LD : LD + pix_cnt), LW'(o_pix_data));
    end
  end

  task automatic wait_line();
    int n;
    n = 0;
    @(posedge i_ref_clk);
    #1;
    while (o_line_start !== 1'b1 && n < 20000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check("line start seen", LW'(1), LW'(n < 20000));
    @(posedge i_ref_clk);
    #1;
  endtask

  // Shortest line: length, strobes and one reset pulse per pixel
  task automatic t_line_base();
    wait_line();
    wait_line();
    check("line length", LW'(L0), LW'(len_last));
    check("converts per line", LW'(NP), LW'(conv_last));
    check("reset pulses", LW'(b_last), LW'(rg_last));
    check("pixels clocked", LW'(1), LW'(b_last >= NP));
    check("exposure", LW'(1), LW'(exposure >= INTEG_MIN_CYC));
  endtask

  // Consumer stalls 3000 cycles, then the FIFO must refuse; sensor then answers slowly
  task automatic t_fifo_full();
    @(posedge i_ref_clk);
    i_pix_ready <= 1'b0;
    repeat (3000) @(posedge i_ref_clk);
    #1;
    check("adc ready when full", LW'(0), LW'(o_adc_ready));
    check("pixel held", LW'(1), LW'(o_pix_valid));
    @(posedge i_ref_clk);
    i_pix_ready <= 1'b1;
    stall       <= 1'b1;
    repeat (500) @(posedge i_ref_clk);
    stall <= 1'b0;
    wait_line();
    check("stream drained", LW'(0), LW'(o_pix_valid));
    wait_line();
    check("effective pixels", LW'(NE), LW'(pix_last));
  endtask

  // Long integration stretches the line; dummies flush before the transfer
  task automatic t_integ_long();
    @(posedge i_ref_clk);
    i_integ_len <= LW'(9000);
    wait_line();
    wait_line();
    check("long line length", LW'(9000 + 2750), LW'(len_last));
    check("converts long line", LW'(NP), LW'(conv_last));
    check("dummy pixels", LW'(1), LW'(b_last > NP));
    check("reset pulses long", LW'(b_last), LW'(rg_last));
    check("reported integration", LW'(9000), o_integ_act);
    check("exposure long", LW'(1), LW'(exposure >= INTEG_MIN_CYC));
  endtask

  initial begin
    i_rst_b     = 1'b0;
    i_integ_len = '0;
    i_pix_ready = 1'b1;
    stall       = 1'b0;
    // Held past four link edges so the FIFO write side leaves reset too
    repeat (130) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_line_base();
    t_fifo_full();
    t_integ_long();
    report_and_stop();
  end

endmodule : test_ccdt_top

`default_nettype wire
